// [sbcu_pkg.sv]
// Shared constants and types of the skip, compare and branch unit
package sbcu_pkg;

  localparam int          PC_W          = 13;
  localparam int          DADDR_W       = 8;
  localparam int          NIB_W         = 4;
  localparam int          NUM_REGS      = 16;
  localparam int          DISP_W        = 6;
  localparam int          BLOCK_LSB     = 12;
  localparam int          PAGE_LSB      = 8;
  localparam logic [12:0] PC_RESET      = 13'h0000;
  localparam logic [3:0]  NIB_ALL_ONES  = 4'hF;
  localparam logic [7:0]  PAIR_ALL_ONES = 8'hFF;
  localparam logic [3:0]  NIB_ONE       = 4'h1;
  localparam logic [7:0]  PAIR_ONE      = 8'h01;
  localparam logic [3:0]  REG_RESET     = 4'h0;

  // Register index: bit 3 selects the alternate bank, then X A H L D E B C
  localparam logic [3:0]  REG_X         = 4'h0;
  localparam logic [3:0]  REG_A         = 4'h1;
  localparam logic [3:0]  REG_H         = 4'h2;
  localparam logic [3:0]  REG_L         = 4'h3;
  localparam logic [3:0]  REG_D         = 4'h4;
  localparam logic [3:0]  REG_E         = 4'h5;

  typedef enum logic [4:0] {
    OP_NOP,
    OP_DECREMENT_SKIP_REG,
    OP_DECREMENT_SKIP_PAIR,
    OP_SKIP_IF_EQUAL_REG_IMM,
    OP_SKIP_IF_EQUAL_MEM_IMM,
    OP_SKIP_IF_EQUAL_A_MEM,
    OP_SKIP_IF_EQUAL_XA_MEM,
    OP_SKIP_IF_EQUAL_A_REG,
    OP_SKIP_IF_EQUAL_XA_PAIR,
    OP_BIT_SET_CARRY,
    OP_BIT_CLEAR_CARRY,
    OP_BIT_INVERT_CARRY,
    OP_SKIP_IF_TRUE_CARRY,
    OP_BIT_SET_OP,
    OP_BIT_CLEAR_OP,
    OP_SKIP_IF_TRUE,
    OP_SKIP_IF_FALSE,
    OP_SKIP_TRUE_THEN_CLEAR,
    OP_CARRY_AND_BIT,
    OP_CARRY_OR_BIT,
    OP_CARRY_XOR_BIT,
    OP_BRANCH_ABS,
    OP_BRANCH_REL,
    OP_BLOCK_LOCAL_BRANCH,
    OP_PAGE_BRANCH_SECOND_PAIR,
    OP_PAGE_BRANCH_ACCUM_PAIR
  } sbcu_opcode_t;

  typedef struct packed {
    sbcu_opcode_t opcode;
    logic [1:0]   len;
    logic [3:0]   rsel;
    logic [2:0]   psel;
    logic [3:0]   imm;
    logic [1:0]   bitsel;
    logic [7:0]   maddr;
    logic [12:0]  addr;
    logic [5:0]   disp;
  } sbcu_op_t;

  typedef struct packed {
    logic       rd;
    logic       we;
    logic [7:0] addr;
    logic [3:0] wdata;
  } sbcu_dmem_req_t;

  typedef logic [15:0][3:0] sbcu_regfile_t;

endpackage : sbcu_pkg

// [sbcu_bitop.sv]
// Single bit pick and replace within a data nibble
`timescale 1ns/1ps
module sbcu_bitop (
  input  wire logic [sbcu_pkg::NIB_W-1:0] nibble_i,
  input  wire logic [1:0]                 bitsel_i,
  input  wire logic                       value_i,
  output logic                            bit_o,
  output logic [sbcu_pkg::NIB_W-1:0]      nibble_o
);
  import sbcu_pkg::*;

  assign bit_o = nibble_i[bitsel_i];

  for (genvar g = 0; g < NIB_W; g++) begin : g_bit
    // Other three bits pass unchanged
    assign nibble_o[g] = (bitsel_i == 2'(g)) ? value_i : nibble_i[g];
  end

endmodule : sbcu_bitop

// [sbcu_target.sv]
// Branch target and sequential program counter computation
`timescale 1ns/1ps
module sbcu_target (
  input  wire sbcu_pkg::sbcu_opcode_t     opcode_i,
  input  wire logic [sbcu_pkg::PC_W-1:0]  pc_i,
  input  wire logic [1:0]                 len_i,
  input  wire logic [sbcu_pkg::PC_W-1:0]  addr_i,
  input  wire logic [sbcu_pkg::DISP_W-1:0] disp_i,
  input  wire logic [7:0]                 second_pair_i,
  input  wire logic [7:0]                 accum_pair_i,
  output logic [sbcu_pkg::PC_W-1:0]       seq_next_o,
  output logic [sbcu_pkg::PC_W-1:0]       target_o,
  output logic                            branch_o
);
  import sbcu_pkg::*;

  logic [PC_W-1:0] rel_target;

  assign seq_next_o = pc_i + PC_W'(len_i);
  // Plain wrap-around add, blind to page and block edges
  assign rel_target = pc_i + PC_W'({{(PC_W-DISP_W){disp_i[DISP_W-1]}}, disp_i});

  always_comb begin
    target_o = seq_next_o;
    branch_o = 1'b1;
    case (opcode_i)
      OP_BRANCH_ABS: begin
        target_o = addr_i;
      end
      OP_BRANCH_REL: begin
        target_o = rel_target;
      end
      OP_BLOCK_LOCAL_BRANCH: begin
        // Top bit from the advanced counter, so 0FFE and 0FFF land in block one
        target_o = {seq_next_o[PC_W-1:BLOCK_LSB], addr_i[BLOCK_LSB-1:0]};
      end
      OP_PAGE_BRANCH_SECOND_PAIR: begin
        target_o = {seq_next_o[PC_W-1:PAGE_LSB], second_pair_i};
      end
      OP_PAGE_BRANCH_ACCUM_PAIR: begin
        target_o = {seq_next_o[PC_W-1:PAGE_LSB], accum_pair_i};
      end
      default: begin
        branch_o = 1'b0;
      end
    endcase
  end

endmodule : sbcu_target

// [sbcu_core.sv]
// Execution core for decrement, compare, carry, bit and branch operations
// Operation
// - Decrement nibble register, skip on F
// - Decrement register pair, skip on FF
// - Skip when register or memory equals immediate
// - Pair memory compare uses even then odd
// - Skip when accumulator pair equals any pair
// - Set, clear and invert the carry flag
// - Skip when carry flag is one
// - Set or clear one memory bit only
// - Skip on memory bit true or false
// - Skip if bit set, then clear it
// - Carry combined with memory bit by logic
// - Absolute branch loads whole program counter
// - Relative branch adds short signed displacement
// - Block branch replaces low twelve bits
// - Block end positions branch into block one
// - Page branch low byte from second pair
// - Page end positions take next page
// - Page branch low byte from accumulator pair
// - Program counter is thirteen bits wide
`timescale 1ns/1ps
module sbcu_core (
  input  wire logic                     sys_clk_i,
  input  wire logic                     reset_n_i,
  input  wire logic                     op_valid_i,
  input  wire sbcu_pkg::sbcu_op_t       op_i,
  output logic                          op_ready_o,
  output sbcu_pkg::sbcu_dmem_req_t      dmem_req_o,
  input  wire logic [sbcu_pkg::NIB_W-1:0] dmem_rdata_i,
  output logic [sbcu_pkg::PC_W-1:0]     pc_o,
  output logic                          carry_o,
  output logic                          skip_o,
  output sbcu_pkg::sbcu_regfile_t       regs_o
);
  import sbcu_pkg::*;

  typedef enum logic [2:0] {
    S_IDLE,
    S_READ,
    S_DATA,
    S_READ2,
    S_DATA2,
    S_WRITE
  } sbcu_fsm_t;

  typedef struct packed {
    sbcu_fsm_t      fsm;
    logic           ready;
    logic [12:0]    pc;
    logic           carry;
    logic           skip;
    logic           match;
    sbcu_op_t       op;
    sbcu_dmem_req_t req;
    sbcu_regfile_t  regs;
  } sbcu_state_t;

  sbcu_state_t     cur;
  sbcu_state_t     next_cur;
  logic            accept;
  logic            exec;
  logic [3:0]      hi_idx;
  logic [3:0]      lo_idx;
  logic [3:0]      sel_nib;
  logic [7:0]      sel_pair;
  logic [7:0]      xa_pair;
  logic [7:0]      de_pair;
  logic [7:0]      pointer_pair;
  logic [3:0]      dec_nib;
  logic [7:0]      dec_pair;
  logic [PC_W-1:0] seq_next;
  logic [PC_W-1:0] target;
  logic            branch;
  logic            mem_bit;
  logic            bit_value;
  logic [3:0]      mod_nib;
  logic            seq_block;
  logic [4:0]      seq_page;

  assign accept       = op_valid_i && cur.ready;
  assign exec         = accept && !cur.skip;
  assign hi_idx       = {op_i.psel, 1'b0};
  assign lo_idx       = {op_i.psel, 1'b1};
  assign sel_nib      = cur.regs[op_i.rsel];
  assign sel_pair     = {cur.regs[hi_idx], cur.regs[lo_idx]};
  // Working pairs are taken from the primary bank
  assign xa_pair      = {cur.regs[REG_X], cur.regs[REG_A]};
  assign de_pair      = {cur.regs[REG_D], cur.regs[REG_E]};
  assign pointer_pair = {cur.regs[REG_H], cur.regs[REG_L]};
  assign dec_nib      = sel_nib - NIB_ONE;
  assign dec_pair     = sel_pair - PAIR_ONE;
  assign seq_block    = seq_next[PC_W-1];
  assign seq_page     = seq_next[PC_W-1:PAGE_LSB];
  assign bit_value    = (cur.op.opcode == OP_BIT_SET_OP);

  sbcu_target sbcu_target_inst (
    .opcode_i      (op_i.opcode),
    .pc_i          (cur.pc),
    .len_i         (op_i.len),
    .addr_i        (op_i.addr),
    .disp_i        (op_i.disp),
    .second_pair_i (de_pair),
    .accum_pair_i  (xa_pair),
    .seq_next_o    (seq_next),
    .target_o      (target),
    .branch_o      (branch)
  );

  sbcu_bitop sbcu_bitop_inst (
    .nibble_i (dmem_rdata_i),
    .bitsel_i (cur.op.bitsel),
    .value_i  (bit_value),
    .bit_o    (mem_bit),
    .nibble_o (mod_nib)
  );

  always_comb begin
    next_cur        = cur;
    next_cur.req.rd = 1'b0;
    next_cur.req.we = 1'b0;
    case (cur.fsm)
      S_IDLE: begin
        if (accept && cur.skip) begin
          // Fetched, but only the counter moves on and the skip flag clears
          next_cur.pc   = seq_next;
          next_cur.skip = 1'b0;
        end else if (accept) begin
          next_cur.op   = op_i;
          next_cur.pc   = branch ? target : seq_next;
          next_cur.skip = 1'b0;
          case (op_i.opcode)
            OP_DECREMENT_SKIP_REG: begin
              next_cur.regs[op_i.rsel] = dec_nib;
              next_cur.skip            = (dec_nib == NIB_ALL_ONES);
            end
            OP_DECREMENT_SKIP_PAIR: begin
              next_cur.regs[hi_idx] = dec_pair[7:4];
              next_cur.regs[lo_idx] = dec_pair[3:0];
              next_cur.skip         = (dec_pair == PAIR_ALL_ONES);
            end
            OP_SKIP_IF_EQUAL_REG_IMM: begin
              next_cur.skip = (sel_nib == op_i.imm);
            end
            OP_SKIP_IF_EQUAL_A_REG: begin
              next_cur.skip = (cur.regs[REG_A] == sel_nib);
            end
            OP_SKIP_IF_EQUAL_XA_PAIR: begin
              next_cur.skip = (xa_pair == sel_pair);
            end
            OP_BIT_SET_CARRY: begin
              next_cur.carry = 1'b1;
            end
            OP_BIT_CLEAR_CARRY: begin
              next_cur.carry = 1'b0;
            end
            OP_BIT_INVERT_CARRY: begin
              next_cur.carry = !cur.carry;
            end
            OP_SKIP_IF_TRUE_CARRY: begin
              next_cur.skip = cur.carry;
            end
            OP_SKIP_IF_EQUAL_MEM_IMM,
            OP_SKIP_IF_EQUAL_A_MEM: begin
              next_cur.req.rd   = 1'b1;
              next_cur.req.addr = pointer_pair;
              next_cur.fsm      = S_READ;
            end
            OP_SKIP_IF_EQUAL_XA_MEM: begin
              // Odd pointer is rounded down to its even partner
              next_cur.req.rd   = 1'b1;
              next_cur.req.addr = {pointer_pair[7:1], 1'b0};
              next_cur.fsm      = S_READ;
            end
            OP_BIT_SET_OP,
            OP_BIT_CLEAR_OP,
            OP_SKIP_IF_TRUE,
            OP_SKIP_IF_FALSE,
            OP_SKIP_TRUE_THEN_CLEAR,
            OP_CARRY_AND_BIT,
            OP_CARRY_OR_BIT,
            OP_CARRY_XOR_BIT: begin
              next_cur.req.rd   = 1'b1;
              next_cur.req.addr = op_i.maddr;
              next_cur.fsm      = S_READ;
            end
            default: begin
            end
          endcase
        end
      end
      S_READ: begin
        next_cur.fsm = S_DATA;
      end
      S_DATA: begin
        next_cur.fsm = S_IDLE;
        case (cur.op.opcode)
          OP_SKIP_IF_EQUAL_MEM_IMM: begin
            next_cur.skip = (dmem_rdata_i == cur.op.imm);
          end
          OP_SKIP_IF_EQUAL_A_MEM: begin
            next_cur.skip = (dmem_rdata_i == cur.regs[REG_A]);
          end
          OP_SKIP_IF_EQUAL_XA_MEM: begin
            next_cur.match    = (dmem_rdata_i == cur.regs[REG_A]);
            next_cur.req.rd   = 1'b1;
            next_cur.req.addr = {cur.req.addr[7:1], 1'b1};
            next_cur.fsm      = S_READ2;
          end
          OP_BIT_SET_OP,
          OP_BIT_CLEAR_OP: begin
            // Read-modify-write keeps the neighbouring bits intact
            next_cur.req.we    = 1'b1;
            next_cur.req.wdata = mod_nib;
            next_cur.fsm       = S_WRITE;
          end
          OP_SKIP_IF_TRUE: begin
            next_cur.skip = mem_bit;
          end
          OP_SKIP_IF_FALSE: begin
            next_cur.skip = !mem_bit;
          end
          OP_SKIP_TRUE_THEN_CLEAR: begin
            // Always writes the zero; harmless when the bit was already clear
            next_cur.skip      = mem_bit;
            next_cur.req.we    = 1'b1;
            next_cur.req.wdata = mod_nib;
            next_cur.fsm       = S_WRITE;
          end
          OP_CARRY_AND_BIT: begin
            next_cur.carry = cur.carry & mem_bit;
          end
          OP_CARRY_OR_BIT: begin
            next_cur.carry = cur.carry | mem_bit;
          end
          OP_CARRY_XOR_BIT: begin
            next_cur.carry = cur.carry ^ mem_bit;
          end
          default: begin
          end
        endcase
      end
      S_READ2: begin
        next_cur.fsm = S_DATA2;
      end
      S_DATA2: begin
        next_cur.skip = cur.match && (dmem_rdata_i == cur.regs[REG_X]);
        next_cur.fsm  = S_IDLE;
      end
      S_WRITE: begin
        next_cur.fsm = S_IDLE;
      end
      default: begin
        next_cur.fsm = S_IDLE;
      end
    endcase
    next_cur.ready = (next_cur.fsm == S_IDLE);
  end

  always_ff @(posedge sys_clk_i) begin
    if (!reset_n_i) begin
      cur       <= '0;
      cur.fsm   <= S_IDLE;
      cur.ready <= 1'b1;
      cur.pc    <= PC_RESET;
    end else begin
      cur <= next_cur;
    end
  end

  assign op_ready_o = cur.ready;
  assign dmem_req_o = cur.req;
  assign pc_o       = cur.pc;
  assign carry_o    = cur.carry;
  assign skip_o     = cur.skip;
  assign regs_o     = cur.regs;

  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (!reset_n_i);

  dec_nibble_skip_a: assert property (
    exec && op_i.opcode == OP_DECREMENT_SKIP_REG |=> skip_o == ($past(sel_nib) == 4'h0)
  ) else $error("nibble decrement skip wrong");

  dec_pair_skip_a: assert property (
    exec && op_i.opcode == OP_DECREMENT_SKIP_PAIR
    |=> skip_o == ($past(sel_pair) == 8'h00)
  ) else $error("pair decrement skip wrong");

  pair_compare_a: assert property (
    exec && op_i.opcode == OP_SKIP_IF_EQUAL_XA_PAIR
    |=> skip_o == ($past(xa_pair) == $past(sel_pair))
  ) else $error("pair compare skip wrong");

  carry_invert_a: assert property (
    exec && op_i.opcode == OP_BIT_INVERT_CARRY |=> carry_o != $past(cur.carry)
  ) else $error("carry invert wrong");

  carry_skip_a: assert property (
    exec && op_i.opcode == OP_SKIP_IF_TRUE_CARRY |=> skip_o == $past(cur.carry)
  ) else $error("carry skip wrong");

  bit_write_a: assert property (
    exec && (op_i.opcode == OP_BIT_SET_OP || op_i.opcode == OP_BIT_CLEAR_OP)
    |=> dmem_req_o.rd && !op_ready_o ##2 dmem_req_o.we ##1 op_ready_o
  ) else $error("bit write sequence wrong");

  pair_mem_addr_a: assert property (
    exec && op_i.opcode == OP_SKIP_IF_EQUAL_XA_MEM
    |=> dmem_req_o.rd && !dmem_req_o.addr[0] ##2 dmem_req_o.rd && dmem_req_o.addr[0]
  ) else $error("pair memory addresses wrong");

  abs_branch_a: assert property (
    exec && op_i.opcode == OP_BRANCH_ABS |=> pc_o == $past(op_i.addr)
  ) else $error("absolute branch target wrong");

  block_branch_a: assert property (
    exec && op_i.opcode == OP_BLOCK_LOCAL_BRANCH
    |=> pc_o[12] == $past(seq_block) && pc_o[11:0] == $past(op_i.addr[11:0])
  ) else $error("block branch target wrong");

  page_branch_a: assert property (
    exec && op_i.opcode == OP_PAGE_BRANCH_SECOND_PAIR
    |=> pc_o == {$past(seq_page), $past(de_pair)}
  ) else $error("page branch target wrong");

  skip_suppress_a: assert property (
    accept && cur.skip
    |=> !skip_o && op_ready_o && pc_o == $past(seq_next)
        && carry_o == $past(cur.carry) && regs_o == $past(cur.regs)
  ) else $error("skipped instruction took effect");

  skip_taken_c: cover property (accept && cur.skip);
  block_cross_c: cover property (
    exec && op_i.opcode == OP_BLOCK_LOCAL_BRANCH && cur.pc == 13'h0FFE);
  page_cross_c: cover property (
    exec && op_i.opcode == OP_PAGE_BRANCH_ACCUM_PAIR && cur.pc[7:0] == 8'hFF);
  test_clear_c: cover property (
    cur.fsm == S_DATA && cur.op.opcode == OP_SKIP_TRUE_THEN_CLEAR && mem_bit);

endmodule : sbcu_core

// [sbcu_dmem_model.sv]
// Behavioural data memory facing the unit's memory port
`timescale 1ns/1ps
module sbcu_dmem_model (
  input  wire logic                  sys_clk_i,
  input  wire sbcu_pkg::sbcu_dmem_req_t dmem_req_i,
  output logic [sbcu_pkg::NIB_W-1:0] rdata_o
);
  import sbcu_pkg::*;
  logic [3:0] mem [256];

  initial begin
    rdata_o = 4'h0;
  end

  // Read data lasts one cycle only, then toggles every cycle, so stale data returns only every second cycle
  always @(posedge sys_clk_i) begin
    if (dmem_req_i.we) begin
      mem[dmem_req_i.addr] <= dmem_req_i.wdata;
    end
    if (dmem_req_i.rd) begin
      rdata_o <= mem[dmem_req_i.addr];
    end else begin
      rdata_o <= ~rdata_o;
    end
  end
endmodule : sbcu_dmem_model

// [skip_compare_branch_unit_tb.sv]
// Self-checking testbench of the skip, compare and branch unit
`timescale 1ns/1ps
module skip_compare_branch_unit_tb;
  import sbcu_pkg::*;
  logic           sys_clk_i;
  logic           reset_n_i;
  logic           op_valid_i;
  sbcu_op_t       op_i;
  logic           op_ready_o;
  sbcu_dmem_req_t dmem_req_o;
  logic [3:0]     dmem_rdata_i;
  logic [12:0]    pc_o;
  logic           carry_o;
  logic           skip_o;
  sbcu_regfile_t  regs_o;
  sbcu_op_t       op;
  int             fails;
  int             check_count;

  sbcu_core sbcu_core_inst (
    .sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i), .op_valid_i(op_valid_i), .op_i(op_i),
    .op_ready_o(op_ready_o), .dmem_req_o(dmem_req_o), .dmem_rdata_i(dmem_rdata_i),
    .pc_o(pc_o), .carry_o(carry_o), .skip_o(skip_o), .regs_o(regs_o));

  sbcu_dmem_model sbcu_dmem_model_inst (
    .sys_clk_i(sys_clk_i), .dmem_req_i(dmem_req_o), .rdata_o(dmem_rdata_i));

  always #2.5 sys_clk_i = ~sys_clk_i;

  task automatic summarize;
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : summarize

  task automatic chk(input string nm, input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  task automatic setop(input sbcu_opcode_t oc, input logic [1:0] ln);
    op = '0;
    op.opcode = oc;
    op.len = ln;
  endtask : setop

  task automatic wm(input logic [7:0] a, input logic [3:0] d);
    sbcu_dmem_model_inst.mem[a] = d;
  endtask : wm

  // Request held until the taking edge, then wait for ready under a bound
  task automatic exec;
    int n;
    n = 0;
    @(negedge sys_clk_i);
    op_valid_i = 1'b1;
    op_i = op;
    @(posedge sys_clk_i);
    @(negedge sys_clk_i);
    op_valid_i = 1'b0;
    while (op_ready_o !== 1'b1 && n < 20) begin
      @(negedge sys_clk_i);
      n++;
    end
    if (op_ready_o !== 1'b1) begin
      fails++;
      $display("BAD ready expected 1 seen %b", op_ready_o);
      summarize();
    end
  endtask : exec

  // Runs op, judges skip, then retires a filler so skip is clear again
  task automatic sk(input logic e);
    sbcu_op_t sv;
    sv = op;
    exec();
    chk("skip", {15'h0, skip_o}, {15'h0, e});
    if (skip_o === 1'b1) begin
      setop(OP_NOP, 2'd1);
      exec();
    end
    op = sv;
  endtask : sk

  task automatic cy(input sbcu_opcode_t oc, input logic [1:0] b, input logic e);
    setop(oc, 2'd2);
    op.maddr = 8'h40;
    op.bitsel = b;
    exec();
    chk("carry", {15'h0, carry_o}, {15'h0, e});
  endtask : cy

  task automatic br(input sbcu_opcode_t oc, input logic [12:0] st, input logic [12:0] ad,
                    input logic [5:0] ds, input logic [12:0] e);
    setop(OP_BRANCH_ABS, 2'd3);
    op.addr = st;
    exec();
    setop(oc, 2'd2);
    op.addr = ad;
    op.disp = ds;
    exec();
    chk("pc", {3'h0, pc_o}, {3'h0, e});
  endtask : br

  task automatic t_reset;
    chk("pc", {3'h0, pc_o}, 16'h0000);
    chk("flags", {14'h0, carry_o, skip_o}, 16'h0000);
    $display("test reset done");
  endtask : t_reset

  task automatic t_decrement;
    setop(OP_DECREMENT_SKIP_REG, 2'd1);
    op.rsel = 4'h1;
    exec();
    chk("reg_a", {12'h0, regs_o[1]}, 16'h000F);
    chk("skip", {15'h0, skip_o}, 16'h0001);
    setop(OP_BIT_SET_CARRY, 2'd1);
    exec();
    chk("carry", {15'h0, carry_o}, 16'h0000);
    chk("pc", {3'h0, pc_o}, 16'h0002);
    setop(OP_DECREMENT_SKIP_REG, 2'd1);
    op.rsel = 4'h1;
    sk(1'b0);
    chk("reg_a", {12'h0, regs_o[1]}, 16'h000E);
    setop(OP_DECREMENT_SKIP_PAIR, 2'd2);
    op.psel = 3'h1;
    sk(1'b1);
    sk(1'b0);
    chk("pair_hl", {8'h0, regs_o[2], regs_o[3]}, 16'h00FE);
    $display("test decrement done");
  endtask : t_decrement

  task automatic t_compare;
    setop(OP_SKIP_IF_EQUAL_REG_IMM, 2'd2);
    op.rsel = 4'h1;
    op.imm = 4'hE;
    sk(1'b1);
    op.imm = 4'hD;
    sk(1'b0);
    wm(8'hFE, 4'h5);
    setop(OP_SKIP_IF_EQUAL_MEM_IMM, 2'd2);
    op.imm = 4'h5;
    sk(1'b1);
    op.imm = 4'h6;
    sk(1'b0);
    setop(OP_SKIP_IF_EQUAL_A_MEM, 2'd1);
    sk(1'b0);
    wm(8'hFE, 4'hE);
    sk(1'b1);
    setop(OP_SKIP_IF_EQUAL_A_REG, 2'd2);
    op.rsel = 4'h1;
    sk(1'b1);
    op.rsel = 4'h0;
    sk(1'b0);
    // Odd pointer: pair compare must fall back to the even address
    setop(OP_DECREMENT_SKIP_PAIR, 2'd2);
    op.psel = 3'h1;
    sk(1'b0);
    wm(8'hFC, 4'hE);
    wm(8'hFD, 4'h0);
    setop(OP_SKIP_IF_EQUAL_XA_MEM, 2'd2);
    sk(1'b1);
    wm(8'hFD, 4'h1);
    sk(1'b0);
    setop(OP_SKIP_IF_EQUAL_XA_PAIR, 2'd2);
    sk(1'b1);
    op.psel = 3'h2;
    sk(1'b0);
    op.psel = 3'h4;
    sk(1'b0);
    $display("test compare done");
  endtask : t_compare

  task automatic t_carry;
    wm(8'h40, 4'h5);
    cy(OP_BIT_SET_CARRY, 2'd0, 1'b1);
    setop(OP_SKIP_IF_TRUE_CARRY, 2'd2);
    sk(1'b1);
    cy(OP_BIT_INVERT_CARRY, 2'd0, 1'b0);
    setop(OP_SKIP_IF_TRUE_CARRY, 2'd2);
    sk(1'b0);
    cy(OP_BIT_INVERT_CARRY, 2'd0, 1'b1);
    cy(OP_BIT_CLEAR_CARRY, 2'd0, 1'b0);
    cy(OP_BIT_SET_CARRY, 2'd0, 1'b1);
    cy(OP_CARRY_AND_BIT, 2'd1, 1'b0);
    cy(OP_CARRY_OR_BIT, 2'd2, 1'b1);
    cy(OP_CARRY_XOR_BIT, 2'd0, 1'b0);
    $display("test carry done");
  endtask : t_carry

  task automatic t_bits;
    wm(8'h30, 4'h0);
    wm(8'h31, 4'hF);
    setop(OP_BIT_SET_OP, 2'd2);
    op.maddr = 8'h30;
    op.bitsel = 2'd2;
    exec();
    chk("mem30", {12'h0, sbcu_dmem_model_inst.mem[8'h30]}, 16'h0004);
    setop(OP_BIT_CLEAR_OP, 2'd2);
    op.maddr = 8'h31;
    exec();
    chk("mem31", {12'h0, sbcu_dmem_model_inst.mem[8'h31]}, 16'h000E);
    setop(OP_SKIP_IF_TRUE, 2'd2);
    op.maddr = 8'h30;
    op.bitsel = 2'd2;
    sk(1'b1);
    op.opcode = OP_SKIP_IF_FALSE;
    sk(1'b0);
    op.bitsel = 2'd1;
    sk(1'b1);
    setop(OP_SKIP_TRUE_THEN_CLEAR, 2'd2);
    op.maddr = 8'h31;
    op.bitsel = 2'd3;
    sk(1'b1);
    chk("mem31", {12'h0, sbcu_dmem_model_inst.mem[8'h31]}, 16'h0006);
    sk(1'b0);
    $display("test bits done");
  endtask : t_bits

  task automatic t_branch;
    br(OP_BRANCH_ABS, 13'h0000, 13'h1FFF, 6'h00, 13'h1FFF);
    br(OP_BRANCH_REL, 13'h0100, 13'h0000, 6'h31, 13'h00F1);
    br(OP_BRANCH_REL, 13'h00F8, 13'h0000, 6'h10, 13'h0108);
    br(OP_BLOCK_LOCAL_BRANCH, 13'h0500, 13'h0ABC, 6'h00, 13'h0ABC);
    br(OP_BLOCK_LOCAL_BRANCH, 13'h1800, 13'h0ABC, 6'h00, 13'h1ABC);
    br(OP_BLOCK_LOCAL_BRANCH, 13'h0FFE, 13'h0123, 6'h00, 13'h1123);
    br(OP_BLOCK_LOCAL_BRANCH, 13'h0FFF, 13'h0123, 6'h00, 13'h1123);
    setop(OP_DECREMENT_SKIP_PAIR, 2'd2);
    op.psel = 3'h2;
    sk(1'b1);
    br(OP_PAGE_BRANCH_SECOND_PAIR, 13'h0210, 13'h0000, 6'h00, 13'h02FF);
    br(OP_PAGE_BRANCH_SECOND_PAIR, 13'h02FE, 13'h0000, 6'h00, 13'h03FF);
    br(OP_PAGE_BRANCH_SECOND_PAIR, 13'h02FF, 13'h0000, 6'h00, 13'h03FF);
    br(OP_PAGE_BRANCH_ACCUM_PAIR, 13'h0410, 13'h0000, 6'h00, 13'h040E);
    br(OP_PAGE_BRANCH_ACCUM_PAIR, 13'h05FF, 13'h0000, 6'h00, 13'h060E);
    $display("test branch done");
  endtask : t_branch

  initial begin
    sys_clk_i = 1'b0;
    reset_n_i = 1'b0;
    op_valid_i = 1'b0;
    op_i = '0;
    fails = 0;
    check_count = 0;
    repeat (3) @(negedge sys_clk_i);
    reset_n_i = 1'b1;
    t_reset();
    t_decrement();
    t_compare();
    t_carry();
    t_bits();
    t_branch();
    summarize();
  end
endmodule : skip_compare_branch_unit_tb
